// >>> include/brcal_pkg.sv
package brcal_pkg;

  localparam int SYS_PERIOD_NS   = 50;
  localparam int MCLK_PERIOD_NS  = 250;
  localparam int MOD_CYCLE_MCLKS = 32;
  localparam int MOD_CYCLE_NS    = MCLK_PERIOD_NS * MOD_CYCLE_MCLKS;
  // Least time, so round up to whole system clocks.
  localparam logic [15:0] BLANK_CYCLES =
    16'((MOD_CYCLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_PERIOD  = 8'h0c;
  localparam logic [7:0] OFS_LIMIT   = 8'h10;
  localparam logic [7:0] OFS_ELAPSED = 8'h14;

  localparam int CFG_RANGE_LSB   = 0;
  localparam int CFG_CHOP        = 2;
  localparam int CFG_AC          = 3;
  localparam int CFG_FORCE80     = 4;
  localparam int CFG_AUTO_CONV   = 5;
  localparam int CFG_AUTO_SINGLE = 6;
  localparam int CFG_WIDTH       = 7;
  localparam logic [6:0] CFG_RESET = 7'h04;

  localparam int STB_BUSY        = 0;
  localparam int STB_NEED_ZERO   = 1;
  localparam int STB_ZERO_VALID  = 2;
  localparam int STB_FULL_DONE   = 3;
  localparam int STB_ERR_SEQ     = 4;
  localparam int STB_ERR_LIMIT   = 5;
  localparam int STB_ERR_TIMEOUT = 6;
  localparam int STB_MODE_LSB    = 8;

  localparam int LIM_FS_LSB   = 0;
  localparam int LIM_SPAN_LSB = 8;
  localparam logic [23:0] PERIOD_RESET   = 24'h000800;
  localparam logic [7:0]  FS_PCT_RESET   = 8'h64;
  localparam logic [7:0]  SPAN_PCT_RESET = 8'h64;
  localparam logic [7:0]  FS_POINT_MAX_PCT = 8'h69;
  localparam logic [7:0]  SPAN_MIN_PCT     = 8'h50;
  localparam logic [7:0]  SPAN_MAX_PCT     = 8'hd2;

  // Calibration lengths in output-rate periods: 44, 48, 22, 24.
  localparam logic [7:0] INT_FULL_CHOP   = 8'h2c;
  localparam logic [7:0] INT_FULL_NOCHOP = 8'h30;
  localparam logic [7:0] ONE_STEP_CHOP   = 8'h16;
  localparam logic [7:0] ONE_STEP_NOCHOP = 8'h18;
  localparam int TIMEOUT_SHIFT = 1;

  localparam logic [1:0] RANGE_80MV = 2'h3;

  typedef enum logic [2:0] {
    MODE_IDLE     = 3'h0,
    MODE_CONT     = 3'h1,
    MODE_SINGLE   = 3'h2,
    MODE_RESV3    = 3'h3,
    MODE_INT_ZERO = 3'h4,
    MODE_INT_FULL = 3'h5,
    MODE_SYS_ZERO = 3'h6,
    MODE_SYS_FULL = 3'h7
  } brcal_mode_t;

  typedef struct packed {
    brcal_mode_t op_mode;
    logic [1:0]  input_range;
    logic        chop_enable;
    logic        alternating_excitation_select;
  } brcal_mode_word_t;

endpackage : brcal_pkg

// >>> src/brcal_host.sv
// How it works
// - Internal full-scale cal is mode 101.
// - Internal zero-scale cal is mode 100.
// - Zero-scale cal must follow internal full-scale.
// - Prefer 80 mV range for internal full-scale.
// - Host writes 001 or 010 for conversions.
// - Host ignores ready one modulator cycle.
// - Hold zero-scale input stable during cal.
// - Hold full-scale input stable during cal.
// - Zero-scale before system full-scale.
// - System full-scale needs valid zero coefficients.
// - Full-scale point at most 1.05 nominal.
// - Span between 0.8 and 2.1 nominal.
`timescale 1ns/100ps
`default_nettype none

module brcal_host
  import brcal_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  output var  logic             mode_req,
  output var  brcal_mode_word_t mode_word,
  input  wire logic             mode_ack,
  input  wire logic             rdy_n,
  output var  logic             hold_stimulus
);

  typedef enum logic [2:0] {S_IDLE, S_SEND, S_BLANK, S_RUN} brcal_state_t;

  brcal_state_t           state_reg;
  logic [CFG_WIDTH-1:0]   cfg_reg;
  logic [23:0]            period_reg;
  logic [7:0]             fs_pct_reg;
  logic [7:0]             span_pct_reg;
  logic [31:0]            elapsed_reg;
  logic [31:0]            limit_reg;
  logic [15:0]            blank_reg;
  logic                   cur_is_cal_reg;
  brcal_mode_t            cur_mode_reg;
  brcal_mode_t            shadow_mode_reg;
  logic                   need_zero_reg;
  logic                   zero_valid_reg;
  logic                   full_done_reg;
  logic                   err_seq_reg;
  logic                   err_limit_reg;
  logic                   err_timeout_reg;
  logic                   rdy_meta_reg;
  logic                   rdy_sync_reg;

  logic                   setup;
  logic                   wr_en;
  logic                   cmd_take;
  brcal_mode_t            cmd_mode;
  logic                   busy;
  logic                   seq_bad;
  logic                   lim_bad;
  logic                   cmd_ok;
  logic                   cal_end;
  logic                   cal_timeout;
  logic                   auto_conv;
  logic [7:0]             exp_periods;
  logic [31:0]            limit_next;
  brcal_mode_word_t       word_next;
  brcal_mode_word_t       conv_word;
  logic [31:0]            status_word;
  logic [31:0]            rd_next;
  logic                   rd_err_next;

  // Ready is a device pin, so it is brought into this clock domain first.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdy_meta_reg <= 1'b1;
      rdy_sync_reg <= 1'b1;
    end
    else if (ce)
    begin
      rdy_meta_reg <= rdy_n;
      rdy_sync_reg <= rdy_meta_reg;
    end
  end

  always_comb
  begin
    setup    = psel && !penable;
    wr_en    = psel && penable && pready && pwrite;
    cmd_mode = brcal_mode_t'(pwdata[2:0]);
    cmd_take = wr_en && (paddr == OFS_CMD);
    busy     = (state_reg != S_IDLE);
    // A lone zero-scale cal is legal whatever came before, unless the host is still busy.
    seq_bad  = busy
            || (((cmd_mode == MODE_CONT) || (cmd_mode == MODE_SINGLE)) && need_zero_reg)
            || ((cmd_mode == MODE_SYS_FULL) && !zero_valid_reg);
    lim_bad  = ((cmd_mode == MODE_SYS_ZERO) || (cmd_mode == MODE_SYS_FULL))
            && ((fs_pct_reg > FS_POINT_MAX_PCT)
            || (span_pct_reg < SPAN_MIN_PCT) || (span_pct_reg > SPAN_MAX_PCT));
    cmd_ok   = cmd_take && !seq_bad && !lim_bad;
  end

  always_comb
  begin
    unique case (cmd_mode)
      MODE_INT_FULL: exp_periods = cfg_reg[CFG_CHOP] ? INT_FULL_CHOP : INT_FULL_NOCHOP;
      MODE_INT_ZERO,
      MODE_SYS_ZERO,
      MODE_SYS_FULL: exp_periods = cfg_reg[CFG_CHOP] ? ONE_STEP_CHOP : ONE_STEP_NOCHOP;
      default:       exp_periods = 8'h00;
    endcase
    // Widen both factors first, so a long period cannot wrap the product.
    limit_next = (32'(exp_periods) * 32'(period_reg)) << TIMEOUT_SHIFT;
    word_next.op_mode = cmd_mode;
    word_next.input_range = ((cmd_mode == MODE_INT_FULL) && cfg_reg[CFG_FORCE80])
                          ? RANGE_80MV : cfg_reg[CFG_RANGE_LSB +: 2];
    word_next.chop_enable = cfg_reg[CFG_CHOP];
    // The device itself falls back to dc excitation on an internal full-scale cal.
    word_next.alternating_excitation_select = cfg_reg[CFG_AC];
    conv_word = mode_word;
    conv_word.op_mode = cfg_reg[CFG_AUTO_SINGLE] ? MODE_SINGLE : MODE_CONT;
    conv_word.input_range = cfg_reg[CFG_RANGE_LSB +: 2];
  end

  // Ready is only trusted once the blanking window has run out.
  always_comb
  begin
    cal_end     = (state_reg == S_RUN) && !rdy_sync_reg;
    cal_timeout = (state_reg == S_RUN) && rdy_sync_reg && (elapsed_reg >= limit_reg);
    auto_conv   = cfg_reg[CFG_AUTO_CONV] && (cur_mode_reg != MODE_INT_FULL);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg      <= S_IDLE;
      cur_is_cal_reg <= 1'b0;
      cur_mode_reg   <= MODE_IDLE;
      blank_reg      <= 16'h0000;
    end
    else if (ce)
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (cmd_ok)
          begin
            state_reg      <= S_SEND;
            cur_is_cal_reg <= cmd_mode[2];
            cur_mode_reg   <= cmd_mode;
          end
        end
        S_SEND:
        begin
          if (mode_ack)
          begin
            state_reg <= cur_is_cal_reg ? S_BLANK : S_IDLE;
            blank_reg <= BLANK_CYCLES;
          end
        end
        S_BLANK:
        begin
          if (blank_reg <= 16'h0001)
          begin
            state_reg <= S_RUN;
          end
          blank_reg <= blank_reg - 16'h0001;
        end
        S_RUN:
        begin
          if (cal_end && auto_conv)
          begin
            state_reg      <= S_SEND;
            cur_is_cal_reg <= 1'b0;
          end
          else if (cal_end || cal_timeout)
          begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mode_req  <= 1'b0;
      mode_word <= '0;
    end
    else if (ce)
    begin
      if ((state_reg == S_IDLE) && cmd_ok)
      begin
        mode_req  <= 1'b1;
        mode_word <= word_next;
      end
      else if ((state_reg == S_SEND) && mode_ack)
      begin
        mode_req <= 1'b0;
      end
      else if (cal_end && auto_conv)
      begin
        mode_req  <= 1'b1;
        mode_word <= conv_word;
      end
    end
  end

  // The external source must be held steady for the whole system cal.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hold_stimulus <= 1'b0;
    end
    else if (ce)
    begin
      if ((state_reg == S_IDLE) && cmd_ok)
      begin
        hold_stimulus <= (cmd_mode == MODE_SYS_ZERO) || (cmd_mode == MODE_SYS_FULL);
      end
      else if (cal_end || cal_timeout)
      begin
        hold_stimulus <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      elapsed_reg <= 32'h0000_0000;
      limit_reg   <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if ((state_reg == S_IDLE) && cmd_ok)
      begin
        elapsed_reg <= 32'h0000_0000;
        limit_reg   <= limit_next;
      end
      else if (((state_reg == S_BLANK) || (state_reg == S_RUN)) && !cal_end)
      begin
        elapsed_reg <= elapsed_reg + 32'h0000_0001;
      end
    end
  end

  // The device drops back to idle by itself, so the local copy follows it when ready ends the cal in S_RUN, not after a timeout.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      shadow_mode_reg <= MODE_IDLE;
    end
    else if (ce)
    begin
      if ((state_reg == S_SEND) && mode_ack)
      begin
        shadow_mode_reg <= mode_word.op_mode;
      end
      else if (cal_end)
      begin
        shadow_mode_reg <= MODE_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      need_zero_reg  <= 1'b0;
      zero_valid_reg <= 1'b0;
      full_done_reg  <= 1'b0;
    end
    else if (ce && cal_end)
    begin
      unique case (cur_mode_reg)
        MODE_INT_FULL:
        begin
          need_zero_reg  <= 1'b1;
          zero_valid_reg <= 1'b0;
          full_done_reg  <= 1'b0;
        end
        MODE_INT_ZERO,
        MODE_SYS_ZERO:
        begin
          need_zero_reg  <= 1'b0;
          zero_valid_reg <= 1'b1;
          full_done_reg  <= full_done_reg || need_zero_reg;
        end
        MODE_SYS_FULL:
        begin
          full_done_reg <= 1'b1;
        end
        default:
        begin
          full_done_reg <= full_done_reg;
        end
      endcase
    end
  end

  // Error flags clear on a written one; a new error in the same cycle wins.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      err_seq_reg     <= 1'b0;
      err_limit_reg   <= 1'b0;
      err_timeout_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd_take && seq_bad)
      begin
        err_seq_reg <= 1'b1;
      end
      else if (wr_en && (paddr == OFS_STATUS) && pwdata[STB_ERR_SEQ])
      begin
        err_seq_reg <= 1'b0;
      end
      if (cmd_take && !seq_bad && lim_bad)
      begin
        err_limit_reg <= 1'b1;
      end
      else if (wr_en && (paddr == OFS_STATUS) && pwdata[STB_ERR_LIMIT])
      begin
        err_limit_reg <= 1'b0;
      end
      if (cal_timeout)
      begin
        err_timeout_reg <= 1'b1;
      end
      else if (wr_en && (paddr == OFS_STATUS) && pwdata[STB_ERR_TIMEOUT])
      begin
        err_timeout_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_reg      <= CFG_RESET;
      period_reg   <= PERIOD_RESET;
      fs_pct_reg   <= FS_PCT_RESET;
      span_pct_reg <= SPAN_PCT_RESET;
    end
    else if (ce && wr_en)
    begin
      if (paddr == OFS_CFG)
      begin
        cfg_reg <= pwdata[CFG_WIDTH-1:0];
      end
      if (paddr == OFS_PERIOD)
      begin
        period_reg <= pwdata[23:0];
      end
      if (paddr == OFS_LIMIT)
      begin
        fs_pct_reg   <= pwdata[LIM_FS_LSB +: 8];
        span_pct_reg <= pwdata[LIM_SPAN_LSB +: 8];
      end
    end
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STB_BUSY]        = busy;
    status_word[STB_NEED_ZERO]   = need_zero_reg;
    status_word[STB_ZERO_VALID]  = zero_valid_reg;
    status_word[STB_FULL_DONE]   = full_done_reg;
    status_word[STB_ERR_SEQ]     = err_seq_reg;
    status_word[STB_ERR_LIMIT]   = err_limit_reg;
    status_word[STB_ERR_TIMEOUT] = err_timeout_reg;
    status_word[STB_MODE_LSB +: 3] = shadow_mode_reg;
    rd_err_next = 1'b0;
    unique case (paddr)
      OFS_CFG:     rd_next = {25'h0000000, cfg_reg};
      OFS_CMD:     rd_next = {29'h00000000, mode_word.op_mode};
      OFS_STATUS:  rd_next = status_word;
      OFS_PERIOD:  rd_next = {8'h00, period_reg};
      OFS_LIMIT:   rd_next = {16'h0000, span_pct_reg, fs_pct_reg};
      OFS_ELAPSED: rd_next = elapsed_reg;
      default:
      begin
        rd_next     = 32'h0000_0000;
        rd_err_next = 1'b1;
      end
    endcase
  end

  // Zero-wait slave: the answer is loaded in the setup cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= setup;
      if (setup)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr <= rd_err_next;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule : brcal_host

`default_nettype wire

// >>> verif/brcal_dev_model.sv
`timescale 1ns/100ps
`default_nettype none

module brcal_dev_model
  import brcal_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             mode_req,
  input  wire brcal_mode_word_t mode_word,
  input  wire logic [15:0]      period_clks,
  input  wire logic             stall,
  output var  logic             mode_ack,
  output var  logic             rdy_n
);
  brcal_mode_t      mode_reg;
  brcal_mode_word_t w;
  int               ofs_updates;
  int               gain_updates;
  logic             dc_used;
  int               n;

  initial
  begin
    mode_ack = 1'b0;
    rdy_n = 1'b0;
    mode_reg = MODE_IDLE;
    ofs_updates = 0;
    gain_updates = 0;
    dc_used = 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (mode_req === 1'b1)
      begin
        repeat ($urandom_range(15)) @(posedge sys_clk);
        w = mode_word;
        mode_ack <= 1'b1;
        mode_reg <= w.op_mode;
        @(posedge sys_clk);
        mode_ack <= 1'b0;
        if (w.op_mode[2])
        begin
          // A late rise punishes a host that trusts ready too soon.
          repeat ($urandom_range(150)) @(posedge sys_clk);
          rdy_n <= 1'b1;
          dc_used = w.op_mode[1] == 1'b0 || !w.alternating_excitation_select;
          if (w.op_mode == MODE_INT_FULL)
            n = w.chop_enable ? 44 : 48;
          else
            n = w.chop_enable ? 22 : 24;
          repeat (n * period_clks) @(posedge sys_clk);
          while (stall) @(posedge sys_clk);
          if (w.op_mode == MODE_SYS_FULL)
            gain_updates++;
          else
            ofs_updates++;
          rdy_n <= 1'b0;
          mode_reg <= MODE_IDLE;
        end
      end
    end
  end
endmodule : brcal_dev_model

`default_nettype wire

// >>> verif/brcal_host_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module brcal_host_assertions
  import brcal_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             ce,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             mode_req,
  input wire brcal_mode_word_t mode_word,
  input wire logic             mode_ack,
  input wire logic             hold_stimulus
);
  logic        need_zero_reg;
  logic        zero_seen_reg;
  logic [15:0] blank_reg;
  wire logic   acked = ce && mode_req && mode_ack;
  wire logic   zero_op = mode_word.op_mode inside {MODE_INT_ZERO, MODE_SYS_ZERO};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // History follows what was sent, which is weaker than what completed.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      need_zero_reg <= 1'b0;
    else if (acked && mode_word.op_mode == MODE_INT_FULL)
      need_zero_reg <= 1'b1;
    else if (acked && zero_op)
      need_zero_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      zero_seen_reg <= 1'b0;
    else if (acked && mode_word.op_mode == MODE_INT_FULL)
      zero_seen_reg <= 1'b0;
    else if (acked && zero_op)
      zero_seen_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      blank_reg <= 16'h0000;
    else if (acked && mode_word.op_mode[2])
      blank_reg <= 16'h0001;
    else if (ce && blank_reg != 16'h0000 && blank_reg <= BLANK_CYCLES)
      blank_reg <= blank_reg + 16'h0001;
  end

  property p_answer;
    ce && psel && !penable |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_ready_once;
    ce && pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_req_hold;
    mode_req && !(ce && mode_ack) |=> mode_req && $stable(mode_word);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
  property p_req_drop;
    acked |=> !mode_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  property p_conv_order;
    $rose(mode_req) && mode_word.op_mode inside {MODE_CONT, MODE_SINGLE} |-> !need_zero_reg;
  endproperty
  a_conv_order: assert property (p_conv_order) else $error("conversion before zero cal");
  property p_full_order;
    $rose(mode_req) && mode_word.op_mode == MODE_SYS_FULL |-> zero_seen_reg;
  endproperty
  a_full_order: assert property (p_full_order) else $error("full cal without zero");
  property p_stim;
    mode_req && mode_word.op_mode[2:1] == 2'b11 |-> hold_stimulus;
  endproperty
  a_stim: assert property (p_stim) else $error("stimulus not held");
  property p_blank;
    $fell(hold_stimulus) |-> blank_reg > BLANK_CYCLES;
  endproperty
  a_blank: assert property (p_blank) else $error("ready trusted too early");
endmodule : brcal_host_assertions

bind brcal_host brcal_host_assertions chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .mode_req(mode_req), .mode_word(mode_word),
  .mode_ack(mode_ack), .hold_stimulus(hold_stimulus)
);

`default_nettype wire

// >>> verif/brcal_host_test.sv
`timescale 1ns/100ps
`default_nettype none

module brcal_host_test
  import brcal_pkg::*;
;
  localparam logic [15:0] PER = 16'h0010;
  logic             sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic             mode_req, mode_ack, rdy_n, hold_stimulus, stall, ce;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [6:0]       cfg;
  brcal_mode_word_t mode_word, last_mw;
  int               fails, tests_run, acks;
  logic [7:0]       fs_t[5] = '{8'h6a, 8'h64, 8'h64, 8'h69, 8'h64};
  logic [7:0]       sp_t[5] = '{8'h64, 8'h4f, 8'hd3, 8'h50, 8'hd2};

  brcal_host dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_req(mode_req), .mode_word(mode_word),
    .mode_ack(mode_ack), .rdy_n(rdy_n), .hold_stimulus(hold_stimulus));
  brcal_dev_model dev_u (.sys_clk(sys_clk), .mode_req(mode_req), .mode_word(mode_word),
    .period_clks(PER), .stall(stall), .mode_ack(mode_ack), .rdy_n(rdy_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (mode_req && mode_ack)
    begin
      last_mw <= mode_word;
      acks <= acks + 1;
    end

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    $display("[FAIL] %0t timeout", $time);
    summarize();
  end

  task automatic summarize();
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    tests_run++;
    if (!(got >= lo && got <= hi))
    begin
      fails++;
      $display("[FAIL] %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_in

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc

  task automatic cmd(input brcal_mode_t m);
    apb(1'b1, OFS_CMD, {29'h0, m});
  endtask : cmd

  function automatic brcal_mode_word_t expw(input logic [6:0] c, input brcal_mode_t op);
    expw.op_mode = op;
    if (c[CFG_AUTO_CONV] && op != MODE_INT_FULL)
      expw.op_mode = c[CFG_AUTO_SINGLE] ? MODE_SINGLE : MODE_CONT;
    expw.input_range = (c[CFG_FORCE80] && op == MODE_INT_FULL) ? RANGE_80MV : c[1:0];
    expw.chop_enable = c[CFG_CHOP];
    expw.alternating_excitation_select = c[CFG_AC];
  endfunction : expw

  // Waits on acknowledges first; busy does not drop between the cal and an auto conversion.
  task automatic cal(input logic [6:0] c, input brcal_mode_t op);
    int k;
    int n;
    k = acks + 1 + int'(c[CFG_AUTO_CONV] && op != MODE_INT_FULL);
    n = 0;
    apb(1'b1, OFS_CFG, {25'h0, c});
    cmd(op);
    while (acks < k && n < 5000)
    begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[STB_BUSY] !== 1'b0 && n < 2000);
    chk({25'h0, last_mw}, {25'h0, expw(c, op)});
  endtask : cal

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall = 1'b0;
    ce = 1'b1;
    fails = 0;
    tests_run = 0;
    acks = 0;
    void'($urandom(32'h033a6359));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(OFS_CFG, 32'h7f, {25'h0, CFG_RESET});
    rdc(OFS_PERIOD, 32'hffffff, {8'h0, PERIOD_RESET});
    rdc(OFS_LIMIT, 32'hffff, {16'h0, SPAN_PCT_RESET, FS_PCT_RESET});
    rdc(OFS_STATUS, 32'h77f, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // With the clock enable low the block is frozen, so this write must not land.
    ce <= 1'b0;
    apb(1'b1, OFS_LIMIT, 32'h0000_1234);
    ce <= 1'b1;
    rdc(OFS_LIMIT, 32'hffff, {16'h0, SPAN_PCT_RESET, FS_PCT_RESET});
    apb(1'b1, OFS_PERIOD, {16'h0, PER});
    cmd(MODE_SYS_FULL);
    rdc(OFS_STATUS, 32'h11, 32'h10);
    apb(1'b1, OFS_STATUS, 32'h70);
    cal(7'h14, MODE_INT_FULL);
    rdc(OFS_STATUS, 32'h706, 32'h2);
    cmd(MODE_CONT);
    rdc(OFS_STATUS, 32'h11, 32'h10);
    apb(1'b1, OFS_STATUS, 32'h70);
    cal(7'h01, MODE_INT_ZERO);
    rdc(OFS_STATUS, 32'h6, 32'h4);
    apb(1'b0, OFS_ELAPSED, 32'h0);
    chk_in(rd, 32'h180, 32'h248);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, OFS_LIMIT, {16'h0, sp_t[i], fs_t[i]});
      if (i < 3)
      begin
        cmd(MODE_SYS_ZERO);
        rdc(OFS_STATUS, 32'h21, 32'h20);
        apb(1'b1, OFS_STATUS, 32'h70);
      end
      else
      begin
        cal(7'h04, MODE_SYS_ZERO);
        rdc(OFS_STATUS, 32'h20, 32'h0);
      end
    end
    apb(1'b1, OFS_LIMIT, 32'h6464);
    repeat (4)
    begin
      cfg = 7'($urandom()) & 7'h6f;
      cal(cfg, ($urandom() & 1) ? MODE_SYS_FULL : MODE_SYS_ZERO);
    end
    stall <= 1'b1;
    cal(7'h04, MODE_SYS_ZERO);
    rdc(OFS_STATUS, 32'h40, 32'h40);
    stall <= 1'b0;
    summarize();
  end
endmodule : brcal_host_test

`default_nettype wire
